// *** design/orc_regs.svh ***
// Register offsets, field positions, reset values and timing for the rack coupling status block
`ifndef ORC_REGS_SVH
`define ORC_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define ORC_OFF_CTRL     8'h00
`define ORC_OFF_STATUS   8'h04
`define ORC_OFF_IRQ_STAT 8'h08
`define ORC_OFF_IRQ_MASK 8'h0c

// ****************************************************************
// Control fields
// ****************************************************************
`define ORC_CTRL_SLAVE   0
`define ORC_CTRL_INIT    1
`define ORC_CTRL_RST     32'h0000_0000

// ****************************************************************
// Status fields
// ****************************************************************
`define ORC_ST_STATE_LO  0
`define ORC_ST_STATE_HI  3
`define ORC_ST_MODE      4
`define ORC_ST_LINK1     5
`define ORC_ST_LINK2     6

// ****************************************************************
// Interrupt events
// ****************************************************************
`define ORC_EV_LINK1     0
`define ORC_EV_LINK2     1
`define ORC_EV_FAULT     2
`define ORC_EV_READY     3
`define ORC_EV_W         4
`define ORC_EV_RST       4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ORC_CLK_NS       8
`define ORC_DECAY_NS     1000
`define ORC_DECAY_CYC    ((`ORC_DECAY_NS) / (`ORC_CLK_NS))
`define ORC_ACK_STEP     8'h20

`endif

// *** design/orc_pkg.sv ***
// Types shared by the rack coupling status block
package orc_pkg;

   // Module state, one-hot
   typedef enum logic [3:0] {
      ORC_ST_POWERUP = 4'h1,
      ORC_ST_CONFIG  = 4'h2,
      ORC_ST_RUN     = 4'h4,
      ORC_ST_FAULT   = 4'h8
   } orc_state_t;

   // Coupling role
   typedef enum logic {
      ORC_MASTER = 1'b0,
      ORC_SLAVE  = 1'b1
   } orc_mode_t;

endpackage : orc_pkg

// *** design/orc_act_if.sv ***
// Acknowledge strobe and glow level between the top and an activity meter
`timescale 1ns/1ps
`default_nettype none

interface orc_act_if;
   logic ack;
   logic en;
   logic glow;
   modport mon  (input ack, input en, output glow);
   modport user (output ack, output en, input glow);
endinterface : orc_act_if

`default_nettype wire

// *** design/orc_activity.sv ***
// Activity meter: acknowledge density to a pulse-width glow
`timescale 1ns/1ps
`default_nettype none
`include "orc_regs.svh"

module orc_activity #(
   parameter int               LVL_W     = 8,
   parameter logic [LVL_W-1:0] STEP      = `ORC_ACK_STEP,
   parameter int               DECAY_CYC = `ORC_DECAY_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   orc_act_if.mon   act
);
   import orc_pkg::*;

   localparam int TW = $clog2(DECAY_CYC + 1);

   logic [LVL_W-1:0] level_q;
   logic [LVL_W-1:0] pwm_q;
   logic [TW-1:0]    tick_q;
   logic             glow_q;
   logic             tick;

   // Saturating add keeps a burst from wrapping to dark
   function automatic logic [LVL_W-1:0] sat_add(input logic [LVL_W-1:0] a,
                                                input logic [LVL_W-1:0] b);
      logic [LVL_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[LVL_W] ? {LVL_W{1'b1}} : s[LVL_W-1:0];
   endfunction : sat_add

   assign tick = (tick_q == TW'(DECAY_CYC - 1));

   // Decay period counter
   always_ff @(posedge clk) begin
      if (srst)
         tick_q <= '0;
      else if (ce)
         tick_q <= tick ? '0 : tick_q + 1'b1;
   end

   // Level rises per acknowledge, leaks one count per period
   always_ff @(posedge clk) begin
      if (srst || (ce && !act.en))
         level_q <= '0;
      else if (ce && act.ack)
         level_q <= sat_add(level_q, STEP);
      else if (ce && tick && level_q != '0)
         level_q <= level_q - 1'b1;
   end

   // Free running ramp for the brightness compare
   always_ff @(posedge clk) begin
      if (srst)
         pwm_q <= '0;
      else if (ce)
         pwm_q <= pwm_q + 1'b1;
   end

   // Brighter as traffic gets denser, dark with none
   always_ff @(posedge clk) begin
      if (srst)
         glow_q <= 1'b0;
      else if (ce)
         glow_q <= act.en && (level_q > pwm_q);
   end

   assign act.glow = glow_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_ACT_DARK: assert property ((ce && level_q == '0) |=> !glow_q) // see RULE_07
      else $error("activity glows with empty level");
   AST_ACT_RISE: assert property ((ce && act.en && act.ack) |=> level_q != '0) // see RULE_07
      else $error("acknowledge did not raise level");
   AST_ACT_OFF: assert property ((ce && !act.en) |=> (!glow_q && level_q == '0)) // see RULE_09
      else $error("disabled meter still active");
   CV_ACT_GLOW: cover property (ce && act.ack ##[1:300] glow_q);

endmodule : orc_activity

`default_nettype wire

// *** design/orc_status.sv ***
// Mode selection and status indication for the optical rack coupling module
// Function
// RULE_01: Master and slave mode by configuration; master after reset.
// RULE_02: Slave mode uses only the first port pair; second pair idle.
// RULE_03: Master serves up to two slaves, one per port pair.
// RULE_04: Three coupled racks: one master, two slaves.
// RULE_05: Two state lamps encode power-up, configured, running, fault.
// RULE_06: Pair1 startup lamp: sending startups as master, receiving as slave.
// RULE_07: Pair1 activity lamp follows acknowledge density, dark without them.
// RULE_08: Pair2 startup lamp shows startup sending, master mode only.
// RULE_09: Pair2 activity lamp shows slave acknowledges, master mode only.
// RULE_10: Pair1 link lamp lit while its receiver sees valid signal.
// RULE_11: Pair2 link lamp lit on valid receive, master mode only.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "orc_regs.svh"

module orc_status #(
   parameter int DECAY_CYC = `ORC_DECAY_CYC
) (
   input  wire logic          REF_CLK,
   input  wire logic          SRST,
   input  wire logic          CE,
   // Register port
   input  wire logic [7:0]    BUS_ADDR,
   input  wire logic [31:0]   BUS_WDATA,
   input  wire logic          BUS_WR,
   input  wire logic          BUS_RD,
   output logic [31:0]        BUS_RDATA,
   output logic               IRQ,
   // Board state
   input  wire logic          CFG_DONE,
   input  wire logic          SUPPLY_FAULT,
   input  wire logic          HW_FAULT,
   // Link side events
   input  wire logic          PAIR1_STARTUP_TX,
   input  wire logic          PAIR1_STARTUP_RX,
   input  wire logic          PAIR2_STARTUP_TX,
   input  wire logic          PAIR1_ACK,
   input  wire logic          PAIR2_ACK,
   input  wire logic          PAIR1_RX_VALID,
   input  wire logic          PAIR2_RX_VALID,
   // Mode towards the link logic
   output orc_pkg::orc_mode_t MODE_SEL,
   output logic               PAIR2_ENABLE,
   // Indicators
   output logic               MODULE_OK_INDICATOR,
   output logic               MODULE_FAULT_INDICATOR,
   output logic               PAIR1_STARTUP_INDICATOR,
   output logic               PAIR1_ACTIVITY_INDICATOR,
   output logic               PAIR2_STARTUP_INDICATOR,
   output logic               PAIR2_ACTIVITY_INDICATOR,
   output logic               PAIR1_LINK_INDICATOR,
   output logic               PAIR2_LINK_INDICATOR
);
   import orc_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0]        ctrl_q;
   logic [`ORC_EV_W-1:0] ist_q;
   logic [`ORC_EV_W-1:0] imask_q;
   logic [`ORC_EV_W-1:0] ev;
   logic [31:0]        rd_val;
   logic [31:0]        rdata_q;
   orc_state_t         state_q;
   orc_state_t         state_d;
   orc_mode_t          mode;
   logic               fault_in;
   logic               ok_q;
   logic               flt_q;
   logic               p1_start_q;
   logic               p2_start_q;
   logic               p1_link_q;
   logic               p2_link_q;
   logic               p1_link_d;
   logic               p2_link_d;
   logic               p2_en_q;
   logic               wr_ctrl;
   logic               wr_ist;
   logic               wr_imask;

   orc_act_if u_act1_if ();
   orc_act_if u_act2_if ();

   // Address match, shared by the write and read decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : hit

   // ****************************************************************
   // Register writes
   // ****************************************************************
   assign wr_ctrl  = BUS_WR && hit(BUS_ADDR, `ORC_OFF_CTRL);
   assign wr_ist   = BUS_WR && hit(BUS_ADDR, `ORC_OFF_IRQ_STAT);
   assign wr_imask = BUS_WR && hit(BUS_ADDR, `ORC_OFF_IRQ_MASK);

   // Control word; master until software asks otherwise
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         ctrl_q <= `ORC_CTRL_RST; // see RULE_01
      else if (CE && wr_ctrl)
         ctrl_q <= BUS_WDATA;
   end

   // Role decode; racks agree on one master externally
   assign mode = ctrl_q[`ORC_CTRL_SLAVE] ? ORC_SLAVE : ORC_MASTER; // see RULE_01 see RULE_04

   // Second pair only carries traffic as master
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         p2_en_q <= 1'b1;
      else if (CE)
         p2_en_q <= (mode == ORC_MASTER); // see RULE_02 see RULE_03
   end

   assign MODE_SEL     = mode;
   assign PAIR2_ENABLE = p2_en_q;

   // ****************************************************************
   // Module state
   // ****************************************************************
   assign fault_in = SUPPLY_FAULT || HW_FAULT;

   // Fault is terminal: only a reset brings the module back
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ORC_ST_POWERUP: begin
            if (CFG_DONE)
               state_d = ORC_ST_CONFIG;
         end
         ORC_ST_CONFIG: begin
            if (ctrl_q[`ORC_CTRL_INIT])
               state_d = ORC_ST_RUN;
         end
         ORC_ST_RUN: begin
            if (!ctrl_q[`ORC_CTRL_INIT])
               state_d = ORC_ST_CONFIG;
         end
         ORC_ST_FAULT: begin
            state_d = ORC_ST_FAULT;
         end
         default: begin
            state_d = ORC_ST_FAULT;
         end
      endcase
      if (fault_in)
         state_d = ORC_ST_FAULT;
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         state_q <= ORC_ST_POWERUP;
      else if (CE)
         state_q <= state_d;
   end

   // Two lamps, four codes
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ok_q  <= 1'b0;
         flt_q <= 1'b0;
      end else if (CE) begin
         ok_q  <= (state_q == ORC_ST_RUN) || (state_q == ORC_ST_FAULT); // see RULE_05
         flt_q <= (state_q == ORC_ST_CONFIG) || (state_q == ORC_ST_FAULT); // see RULE_05
      end
   end

   // ****************************************************************
   // Link indicators
   // ****************************************************************
   assign p1_link_d = PAIR1_RX_VALID; // see RULE_10
   assign p2_link_d = (mode == ORC_MASTER) && PAIR2_RX_VALID; // see RULE_11

   // Startup and link lamps; pair two is dark as slave
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         p1_start_q <= 1'b0;
         p2_start_q <= 1'b0;
         p1_link_q  <= 1'b0;
         p2_link_q  <= 1'b0;
      end else if (CE) begin
         p1_start_q <= (mode == ORC_MASTER) ? PAIR1_STARTUP_TX : PAIR1_STARTUP_RX; // see RULE_06
         p2_start_q <= (mode == ORC_MASTER) && PAIR2_STARTUP_TX; // see RULE_08
         p1_link_q  <= p1_link_d;
         p2_link_q  <= p2_link_d;
      end
   end

   // Activity meters; a disabled meter is forced dark
   assign u_act1_if.ack = PAIR1_ACK;
   assign u_act1_if.en  = 1'b1; // see RULE_07
   assign u_act2_if.ack = PAIR2_ACK;
   assign u_act2_if.en  = (mode == ORC_MASTER); // see RULE_09

   orc_activity #(
      .DECAY_CYC (DECAY_CYC)
   ) u_act1 (
      .clk  (REF_CLK),
      .srst (SRST),
      .ce   (CE),
      .act  (u_act1_if.mon)
   );

   orc_activity #(
      .DECAY_CYC (DECAY_CYC)
   ) u_act2 (
      .clk  (REF_CLK),
      .srst (SRST),
      .ce   (CE),
      .act  (u_act2_if.mon)
   );

   assign MODULE_OK_INDICATOR      = ok_q;
   assign MODULE_FAULT_INDICATOR   = flt_q;
   assign PAIR1_STARTUP_INDICATOR  = p1_start_q;
   assign PAIR2_STARTUP_INDICATOR  = p2_start_q;
   assign PAIR1_ACTIVITY_INDICATOR = u_act1_if.glow;
   assign PAIR2_ACTIVITY_INDICATOR = u_act2_if.glow;
   assign PAIR1_LINK_INDICATOR     = p1_link_q;
   assign PAIR2_LINK_INDICATOR     = p2_link_q;

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   // Events: link changes, fault entry, reaching run
   always_comb begin
      ev = '0;
      ev[`ORC_EV_LINK1] = (p1_link_d != p1_link_q);
      ev[`ORC_EV_LINK2] = (p2_link_d != p2_link_q);
      ev[`ORC_EV_FAULT] = (state_d == ORC_ST_FAULT) && (state_q != ORC_ST_FAULT);
      ev[`ORC_EV_READY] = (state_d == ORC_ST_RUN) && (state_q != ORC_ST_RUN);
   end

   // Sticky bits, write one to clear; a new event beats the clear
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         ist_q <= `ORC_EV_RST;
      else if (CE)
         ist_q <= (ist_q & ~(wr_ist ? BUS_WDATA[`ORC_EV_W-1:0] : `ORC_EV_RST)) | ev;
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         imask_q <= `ORC_EV_RST;
      else if (CE && wr_imask)
         imask_q <= BUS_WDATA[`ORC_EV_W-1:0];
   end

   // Level output straight from flops
   assign IRQ = |(ist_q & imask_q);

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Unmapped offsets read as zero
   always_comb begin
      rd_val = '0;
      if (hit(BUS_ADDR, `ORC_OFF_CTRL))
         rd_val = ctrl_q;
      if (hit(BUS_ADDR, `ORC_OFF_STATUS)) begin
         rd_val[`ORC_ST_STATE_HI:`ORC_ST_STATE_LO] = state_q;
         rd_val[`ORC_ST_MODE]  = mode;
         rd_val[`ORC_ST_LINK1] = p1_link_q;
         rd_val[`ORC_ST_LINK2] = p2_link_q;
      end
      if (hit(BUS_ADDR, `ORC_OFF_IRQ_STAT))
         rd_val[`ORC_EV_W-1:0] = ist_q;
      if (hit(BUS_ADDR, `ORC_OFF_IRQ_MASK))
         rd_val[`ORC_EV_W-1:0] = imask_q;
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         rdata_q <= '0;
      else if (CE)
         rdata_q <= BUS_RD ? rd_val : '0;
   end

   assign BUS_RDATA = rdata_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   AST_MASTER_AT_RESET: assert property (disable iff (1'b0) SRST |=> MODE_SEL == ORC_MASTER) // see RULE_01
      else $error("mode not master after reset");
   AST_SLAVE_P2_OFF: assert property ((CE && mode == ORC_SLAVE) |=> !PAIR2_ENABLE) // see RULE_02
      else $error("second pair enabled in slave mode");
   AST_RUN_LAMPS: assert property ((CE && state_q == ORC_ST_RUN) |=> // see RULE_05
      (MODULE_OK_INDICATOR && !MODULE_FAULT_INDICATOR))
      else $error("running state shows wrong lamps");
   AST_FAULT_LAMPS: assert property ((CE && fault_in) ##1 CE |=> // see RULE_05
      (MODULE_OK_INDICATOR && MODULE_FAULT_INDICATOR))
      else $error("fault not shown on both lamps");
   AST_POWERUP_DARK: assert property ((CE && state_q == ORC_ST_POWERUP) |=> // see RULE_05
      (!MODULE_OK_INDICATOR && !MODULE_FAULT_INDICATOR))
      else $error("state lamps lit during power-up");
   AST_P1_START: assert property (CE |=> PAIR1_STARTUP_INDICATOR == // see RULE_06
      ($past(mode) == ORC_MASTER ? $past(PAIR1_STARTUP_TX) : $past(PAIR1_STARTUP_RX)))
      else $error("pair1 startup lamp wrong source");
   AST_P2_START: assert property ((CE && mode == ORC_SLAVE) |=> !PAIR2_STARTUP_INDICATOR) // see RULE_08
      else $error("pair2 startup lamp lit as slave");
   AST_P2_ACT: assert property ((CE && mode == ORC_SLAVE) |=> !PAIR2_ACTIVITY_INDICATOR) // see RULE_09
      else $error("pair2 activity lamp lit as slave");
   AST_P1_LINK: assert property (CE |=> PAIR1_LINK_INDICATOR == $past(PAIR1_RX_VALID)) // see RULE_10
      else $error("pair1 link lamp does not follow receiver");
   AST_P2_LINK: assert property ((CE && mode == ORC_MASTER) |=> // see RULE_11
      PAIR2_LINK_INDICATOR == $past(PAIR2_RX_VALID))
      else $error("pair2 link lamp does not follow receiver");
   AST_P1_IDLE: assert property ((CE && !PAIR1_ACK)[*8] |-> ##[0:1000] // see RULE_07
      (!PAIR1_ACTIVITY_INDICATOR || PAIR1_ACK))
      else $error("pair1 activity lamp stays lit without traffic");

   CV_REACH_RUN: cover property (state_q == ORC_ST_RUN);
   CV_SLAVE_START: cover property (mode == ORC_SLAVE && PAIR1_STARTUP_INDICATOR);
   CV_P2_ACTIVE: cover property (PAIR2_ACTIVITY_INDICATOR && PAIR2_LINK_INDICATOR);
   CV_IRQ: cover property (IRQ);

endmodule : orc_status

`default_nettype wire

// *** design/orc_status_end.sv ***
// No logic lives in this unit

// *** tb/orc_peer_model.sv ***
// Far-side coupling partner for one port pair: receive signal and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none

module orc_peer_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       up,
   input  wire logic [7:0] ack_gap,
   output logic            rx_valid,
   output logic            ack
);
   logic [7:0] gap_q;

   // **********
   // Partner behaviour
   // **********
   // Light on the fibre only while the partner is up
   always_ff @(posedge clk) begin
      rx_valid <= !srst && up;
   end

   // A slave partner answers every access; gap 0 means silent, 1 a constant stream
   always_ff @(posedge clk) begin
      if (srst || !up || ack_gap == 8'h00) begin
         gap_q <= 8'h00;
         ack   <= 1'b0;
      end else begin
         gap_q <= (gap_q + 8'h01 >= ack_gap) ? 8'h00 : gap_q + 8'h01;
         ack   <= (gap_q == 8'h00);
      end
   end
endmodule : orc_peer_model

`default_nettype wire

// *** tb/orc_status_tb_top.sv ***
// Self-checking testbench for the rack coupling status block
`timescale 1ns/1ps
`default_nettype none
`include "orc_regs.svh"

module orc_status_tb_top;
   import orc_pkg::*;
   // Fast decay keeps the meter runs short
   localparam int DECAY = 1;
   logic        ref_clk, srst, cfg_done, supply_fault, hw_fault;
   logic        s1_tx, s1_rx, s2_tx, up1, up2, wr, rd_s, ce;
   logic [7:0]  gap1, gap2, addr;
   logic [31:0] wdata, d;
   wire  [31:0] rdata;
   wire  [7:0]  lamps;
   wire         irq, ack1, ack2, v1, v2, p2_en;
   orc_mode_t   mode;
   int          n_errors, samples_checked, c0, c1;

   // **********
   // Design and partners
   // **********
   orc_status #(.DECAY_CYC(DECAY)) dut_u (
      .REF_CLK(ref_clk), .SRST(srst), .CE(ce),
      .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd_s),
      .BUS_RDATA(rdata), .IRQ(irq), .CFG_DONE(cfg_done),
      .SUPPLY_FAULT(supply_fault), .HW_FAULT(hw_fault),
      .PAIR1_STARTUP_TX(s1_tx), .PAIR1_STARTUP_RX(s1_rx), .PAIR2_STARTUP_TX(s2_tx),
      .PAIR1_ACK(ack1), .PAIR2_ACK(ack2), .PAIR1_RX_VALID(v1), .PAIR2_RX_VALID(v2),
      .MODE_SEL(mode), .PAIR2_ENABLE(p2_en),
      .MODULE_OK_INDICATOR(lamps[7]), .MODULE_FAULT_INDICATOR(lamps[6]),
      .PAIR1_STARTUP_INDICATOR(lamps[5]), .PAIR1_ACTIVITY_INDICATOR(lamps[4]),
      .PAIR2_STARTUP_INDICATOR(lamps[3]), .PAIR2_ACTIVITY_INDICATOR(lamps[2]),
      .PAIR1_LINK_INDICATOR(lamps[1]), .PAIR2_LINK_INDICATOR(lamps[0]));
   orc_peer_model peer1_u (.clk(ref_clk), .srst(srst), .up(up1), .ack_gap(gap1),
                           .rx_valid(v1), .ack(ack1));
   orc_peer_model peer2_u (.clk(ref_clk), .srst(srst), .up(up2), .ack_gap(gap2),
                           .rx_valid(v2), .ack(ack2));

   // 125 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // **********
   // Tasks
   // **********
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg

   // Counts lit cycles of one activity lamp
   task automatic glow(input bit p2, input int n, output int c);
      c = 0;
      repeat (n) begin
         step(1);
         c += ((p2 ? lamps[2] : lamps[4]) === 1'b1) ? 1 : 0;
      end
   endtask : glow

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // Hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end

   // **********
   // Main sequence
   // **********
   initial begin
      {srst, cfg_done, supply_fault, hw_fault, s1_tx, s1_rx, s2_tx} = 7'h40;
      {up1, up2, wr, rd_s, ce} = 5'h01;
      {gap1, gap2, addr, wdata} = 56'h0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      step(1);
      chk(32'(lamps), 32'h0, "lamps after reset");
      chk(32'(mode), 32'(ORC_MASTER), "mode after reset");
      chk(32'(p2_en), 32'h1, "pair2 enable after reset");
      rd_reg(`ORC_OFF_STATUS, d);
      chk(d, 32'h01, "status power-up");
      $display("test reset done");

      @(posedge ref_clk);
      cfg_done <= 1'b1;
      step(4);
      chk(32'(lamps & 8'hc0), 32'h40, "configured lamps");
      wr_reg(`ORC_OFF_CTRL, 32'h2);
      step(4);
      chk(32'(lamps & 8'hc0), 32'h80, "running lamps");
      $display("test state done");

      // Master with both partners up and startups going out on both pairs
      @(posedge ref_clk);
      {s1_tx, s1_rx, s2_tx, up1, up2} <= 5'h17;
      step(4);
      chk(32'(lamps & 8'heb), 32'hab, "master lamps");
      @(posedge ref_clk);
      {s1_tx, s1_rx} <= 2'h1;
      step(4);
      chk(32'(lamps & 8'heb), 32'h8b, "master startup follows send");
      rd_reg(`ORC_OFF_IRQ_STAT, d);
      chk(d, 32'h0b, "irq events");
      chk(32'(irq), 32'h0, "irq masked");
      wr_reg(`ORC_OFF_IRQ_MASK, 32'h1);
      step(2);
      chk(32'(irq), 32'h1, "irq unmasked");
      wr_reg(`ORC_OFF_IRQ_STAT, 32'h0b);
      step(2);
      chk(32'(irq), 32'h0, "irq cleared");
      rd_reg(8'h10, d);
      chk(d, 32'h0, "unmapped read");
      // Enable low freezes the lamps and drops a bus strobe
      @(posedge ref_clk);
      {ce, s1_tx} <= 2'b01;
      wr_reg(`ORC_OFF_IRQ_MASK, 32'hf);
      step(1);
      chk(32'(lamps & 8'heb), 32'h8b, "lamps frozen");
      @(posedge ref_clk);
      {ce, s1_tx} <= 2'b10;
      rd_reg(`ORC_OFF_IRQ_MASK, d);
      chk(d, 32'h1, "write lost while frozen");
      $display("test master lamps done");

      // Activity: dark, saturated, then fading with falling density
      glow(1'b0, 64, c0);
      chk(32'(c0), 32'h0, "pair1 dark without acks");
      @(posedge ref_clk);
      {gap1, gap2} <= 16'h0404;
      step(300);
      glow(1'b0, 256, c0);
      glow(1'b1, 256, c1);
      chk(32'(c0 > 200 && c1 > 200), 32'h1, "dense traffic glows");
      @(posedge ref_clk);
      {gap1, gap2} <= 16'h0;
      glow(1'b0, 128, c0);
      glow(1'b0, 128, c1);
      chk(32'(c0 > c1 && c1 > 0), 32'h1, "glow follows density");
      step(300);
      glow(1'b1, 64, c1);
      chk(32'(c1), 32'h0, "pair2 dark without acks");
      $display("test activity done");

      // Slave: pair2 silent whatever its inputs do, pair1 startup from receive
      wr_reg(`ORC_OFF_CTRL, 32'h3);
      {gap1, gap2, s2_tx} <= {8'h01, 8'h04, 1'b1};
      step(300);
      chk(32'(mode), 32'(ORC_SLAVE), "slave mode");
      chk(32'(p2_en), 32'h0, "pair2 off in slave");
      chk(32'(lamps & 8'heb), 32'ha2, "slave lamps");
      glow(1'b1, 256, c1);
      chk(32'(c1), 32'h0, "pair2 meter off in slave");
      glow(1'b0, 256, c0);
      chk(32'(c0 > 200), 32'h1, "pair1 meter in slave");
      rd_reg(`ORC_OFF_STATUS, d);
      chk(d & 32'h3f, 32'h34, "slave status");
      wr_reg(`ORC_OFF_CTRL, 32'h2);
      step(4);
      chk(32'(lamps & 8'heb), 32'h8b, "back to master");
      $display("test slave done");

      // Faults are terminal until reset
      @(posedge ref_clk);
      supply_fault <= 1'b1;
      step(4);
      @(posedge ref_clk);
      supply_fault <= 1'b0;
      step(4);
      chk(32'(lamps & 8'hc0), 32'hc0, "supply fault held");
      @(posedge ref_clk);
      srst <= 1'b1;
      step(3);
      @(posedge ref_clk);
      srst <= 1'b0;
      step(4);
      chk(32'(lamps & 8'hc0), 32'h40, "configured after reset");
      @(posedge ref_clk);
      hw_fault <= 1'b1;
      step(4);
      chk(32'(lamps & 8'hc0), 32'hc0, "hardware fault");
      $display("test fault done");
      test_done();
   end
endmodule : orc_status_tb_top

`default_nettype wire
